// ==== hdl/dram_mode_pkg.sv ====
// package of mode register two and three layouts, latencies and codes
// assumes a single command clock domain; nothing is imported, names are scoped
package dram_mode_pkg;
    // ========================================
    // command bus encodings
    localparam logic [2:0] BANK_SEL_MODE_TWO   = 3'h2;
    localparam logic [2:0] BANK_SEL_MODE_THREE = 3'h3;
    localparam int         MODE_WORD_WIDTH     = 19;

    // ========================================
    // mode register two field positions
    localparam int WCL_LSB       = 3;
    localparam int WCL_MSB       = 5;
    localparam int AUTO_RATE_BIT = 6;
    localparam int FORCED_2X_BIT = 7;
    localparam int DYN_TERM_LSB  = 9;
    localparam int DYN_TERM_MSB  = 10;

    // ========================================
    // mode register three field positions
    localparam int CAL_SEL_LSB = 0;
    localparam int CAL_SEL_MSB = 1;
    localparam int CAL_EN_BIT  = 2;

    // ========================================
    // reset values and codes
    localparam logic [18:0] MODE_TWO_RESET      = 19'h00000;
    localparam logic [18:0] MODE_THREE_RESET    = 19'h00000;
    localparam logic [1:0]  CAL_SEL_PATTERN     = 2'h0;
    localparam logic [7:0]  CAL_PATTERN         = 8'hAA;
    localparam logic [3:0]  WCL_BASE_CYCLES     = 4'h5;
    localparam int          BURST_BEATS         = 8;

    // ========================================
    // temperature thresholds in degrees C
    localparam logic [7:0] TEMP_NORMAL_LIMIT_C  = 8'h55;
    localparam logic [7:0] TEMP_AUTO_MARGIN_C   = 8'h02;

    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_WRITE,
        CMD_READ
    } access_t;
endpackage : dram_mode_pkg

// ==== hdl/dram_write_delay.sv ====
// delay line that releases a write start after a programmable number of cycles
// assumes the launch pulse and latency come from the same clock domain
`timescale 1ns/10ps
module dram_write_delay #(
    parameter int DEPTH = 32
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_launch,
    input  wire logic [4:0]  i_latency,
    output logic             o_release
);
    logic [DEPTH-1:0] pipe_q;

    // ========================================
    // shift register of pending write starts
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pipe_q <= '0;
        end else begin
            pipe_q <= {pipe_q[DEPTH-2:0], i_launch};
        end
    end

    // tap selected by latency, zero means next cycle
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_release <= 1'b0;
        end else begin
            o_release <= (i_latency == 5'h00) ? i_launch : pipe_q[i_latency - 5'h01];
        end
    end
endmodule : dram_write_delay

// ==== hdl/dram_burst_count.sv ====
// counter that holds a flag for one burst of beats after a start pulse
// assumes bursts do not overlap; a new start restarts the count
`timescale 1ns/10ps
module dram_burst_count #(
    parameter int BEATS = 8
) (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_start,
    output logic      o_active,
    output logic [2:0] o_beat
);
    logic [3:0] cnt_q;

    // ========================================
    // beat counter and activity flag
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q    <= 4'h0;
            o_active <= 1'b0;
            o_beat   <= 3'h0;
        end else if (i_start) begin
            cnt_q    <= 4'(BEATS - 1);
            o_active <= 1'b1;
            o_beat   <= 3'h0;
        end else if (cnt_q != 4'h0) begin
            cnt_q    <= cnt_q - 4'h1;
            o_beat   <= o_beat + 3'h1;
        end else begin
            o_active <= 1'b0;
        end
    end
endmodule : dram_burst_count

// ==== hdl/dram_mode_reg_two_three.sv ====
// mode register two and three decode with write latency, refresh rate,
// dynamic termination and calibration readout behaviour
// assumes commands arrive decoded and synchronous to i_mclk; i_case_temp,
// i_nominal_term_en and i_write_leveling come from pins and are synchronised
//
// Summary of operation
// - write column latency is mode register two bits 5:3
// - total write latency is five base cycles plus write column latency plus additive latency
// - bit 6 enables automatic refresh rate; clear leaves the rate to bit 7
// - automatic mode doubles self refresh rate above 85 C, may switch lower
// - bit 7 enables forced extended temperature refresh; clear leaves the rate to bit 6
// - forced extended temperature option always gives double rate
// - bits 10:9 select dynamic write termination; nonzero enables it
// - write termination replaces nominal during each write burst
// - dynamic termination works with nominal disabled; nominal is then high-z
// - no dynamic termination while write leveling is active
// - mode register three holds until rewritten; array is untouched
// - bit 2 clear means normal array access, bits 1:0 ignored
// - bit 2 set returns calibration data; 00 selects the fixed pattern
// - while bit 2 is set, every read and auto precharge read goes to calibration register
// - reset still works while calibration readout is enabled
// - calibration contents may be read repeatedly
// - calibration pattern is alternating zero, one across the burst
// - bank address 010 selects register two, 011 register three
`timescale 1ns/10ps
module dram_mode_reg_two_three #(
    parameter int MAX_LATENCY = 32
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_mode_set,
    input  wire logic [2:0]  i_bank_addr,
    input  wire logic [18:0] i_addr,
    input  wire logic        i_write_cmd,
    input  wire logic        i_read_cmd,
    input  wire logic        i_read_auto_pre,
    input  wire logic [3:0]  i_additive_latency,
    input  wire logic        i_nominal_term_en,
    input  wire logic        i_write_leveling,
    input  wire logic        i_self_refresh,
    input  wire logic [7:0]  i_case_temp,
    input  wire logic [7:0]  i_array_rd_data,
    output logic [4:0]       o_total_write_latency,
    output logic             o_write_data_latch,
    output logic             o_refresh_double_rate,
    output logic             o_refresh_tick,
    output logic [1:0]       o_termination_sel,
    output logic             o_term_high_z,
    output logic             o_calibration_mode,
    output logic             o_array_read_en,
    output logic             o_rd_valid,
    output logic [7:0]       o_rd_data
);
    logic [18:0] mode_two_q;
    logic [18:0] mode_three_q;
    logic [7:0]  temp_meta_q;
    logic [7:0]  temp_q;
    logic        nom_meta_q;
    logic        nom_q;
    logic        lvl_meta_q;
    logic        lvl_q;
    logic        rate_hot_q;
    logic [1:0]  refresh_div_q;
    logic        write_release;
    logic        burst_active;
    logic [2:0]  burst_beat;
    logic [2:0]  read_beat;
    logic        read_active;
    logic        cal_rd_q;
    logic [3:0]  read_left_q;

    logic [2:0] write_column_latency;
    logic       automatic_refresh_rate_adjust;
    logic       forced_extended_temp_refresh;
    logic [1:0] dynamic_write_termination;
    logic       calibration_enable;
    logic [1:0] calibration_select;
    logic       any_read;

    // ========================================
    // pin synchronisers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            temp_meta_q <= 8'h00;
            temp_q      <= 8'h00;
            nom_meta_q  <= 1'b0;
            nom_q       <= 1'b0;
            lvl_meta_q  <= 1'b0;
            lvl_q       <= 1'b0;
        end else begin
            temp_meta_q <= i_case_temp;
            temp_q      <= temp_meta_q;
            nom_meta_q  <= i_nominal_term_en;
            nom_q       <= nom_meta_q;
            lvl_meta_q  <= i_write_leveling;
            lvl_q       <= lvl_meta_q;
        end
    end

    // ========================================
    // mode register capture; contents held until next set, reset clears
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_two_q   <= dram_mode_pkg::MODE_TWO_RESET;
            mode_three_q <= dram_mode_pkg::MODE_THREE_RESET;
        end else if (i_mode_set) begin
            if (i_bank_addr == dram_mode_pkg::BANK_SEL_MODE_TWO) begin
                mode_two_q <= i_addr;
            end else if (i_bank_addr == dram_mode_pkg::BANK_SEL_MODE_THREE) begin
                mode_three_q <= i_addr;
            end
        end
    end

    // field extraction
    assign write_column_latency =
        mode_two_q[dram_mode_pkg::WCL_MSB:dram_mode_pkg::WCL_LSB];
    assign automatic_refresh_rate_adjust = mode_two_q[dram_mode_pkg::AUTO_RATE_BIT];
    assign forced_extended_temp_refresh  = mode_two_q[dram_mode_pkg::FORCED_2X_BIT];
    assign dynamic_write_termination =
        mode_two_q[dram_mode_pkg::DYN_TERM_MSB:dram_mode_pkg::DYN_TERM_LSB];
    assign calibration_enable = mode_three_q[dram_mode_pkg::CAL_EN_BIT];
    assign calibration_select =
        mode_three_q[dram_mode_pkg::CAL_SEL_MSB:dram_mode_pkg::CAL_SEL_LSB];
    assign any_read = i_read_cmd | i_read_auto_pre;

    // ========================================
    // write latency: base plus field plus additive latency
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_total_write_latency <= 5'h00;
        end else begin
            o_total_write_latency <= 5'({1'b0, dram_mode_pkg::WCL_BASE_CYCLES}
                                       + {2'h0, write_column_latency}
                                       + {1'b0, i_additive_latency});
        end
    end

    // delay the write command by total latency
    dram_write_delay #(
        .DEPTH     (MAX_LATENCY)
    ) u_write_delay (
        .i_mclk    (i_mclk),
        .i_rst_n   (i_rst_n),
        .i_launch  (i_write_cmd & ~calibration_enable),
        .i_latency (o_total_write_latency),
        .o_release (write_release)
    );

    // first data beat latch strobe
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_write_data_latch <= 1'b0;
        end else begin
            o_write_data_latch <= write_release;
        end
    end

    // write burst window
    dram_burst_count #(
        .BEATS    (dram_mode_pkg::BURST_BEATS)
    ) u_write_burst (
        .i_mclk   (i_mclk),
        .i_rst_n  (i_rst_n),
        .i_start  (write_release),
        .o_active (burst_active),
        .o_beat   (burst_beat)
    );

    // ========================================
    // self refresh rate selection
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rate_hot_q <= 1'b0;
        end else if (forced_extended_temp_refresh) begin
            rate_hot_q <= 1'b1;
        end else if (automatic_refresh_rate_adjust) begin
            // switch slightly below the limit for margin
            rate_hot_q <= (temp_q > (dram_mode_pkg::TEMP_NORMAL_LIMIT_C
                                     - dram_mode_pkg::TEMP_AUTO_MARGIN_C));
        end else begin
            rate_hot_q <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_refresh_double_rate <= 1'b0;
        end else begin
            o_refresh_double_rate <= rate_hot_q;
        end
    end

    // refresh tick: every fourth cycle single, every second double
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            refresh_div_q  <= 2'h0;
            o_refresh_tick <= 1'b0;
        end else if (i_self_refresh) begin
            refresh_div_q  <= refresh_div_q + 2'h1;
            o_refresh_tick <= rate_hot_q ? refresh_div_q[0] : (refresh_div_q == 2'h3);
        end else begin
            refresh_div_q  <= 2'h0;
            o_refresh_tick <= 1'b0;
        end
    end

    // ========================================
    // termination: 00 off, 01 nominal, 10 write value
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_termination_sel <= 2'h0;
            o_term_high_z     <= 1'b1;
        end else if (burst_active && (dynamic_write_termination != 2'h0)
                     && !lvl_q) begin
            o_termination_sel <= 2'h2;
            o_term_high_z     <= 1'b0;
        end else if (nom_q) begin
            o_termination_sel <= 2'h1;
            o_term_high_z     <= 1'b0;
        end else begin
            o_termination_sel <= 2'h0;
            o_term_high_z     <= 1'b1;
        end
    end

    // ========================================
    // calibration readout mode flag
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_calibration_mode <= 1'b0;
        end else begin
            o_calibration_mode <= calibration_enable;
        end
    end

    // read burst tracker, restartable for repeated readouts
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            read_left_q <= 4'h0;
            cal_rd_q    <= 1'b0;
            read_beat   <= 3'h0;
        end else if (any_read) begin
            read_left_q <= 4'(dram_mode_pkg::BURST_BEATS);
            cal_rd_q    <= calibration_enable;
            read_beat   <= 3'h0;
        end else if (read_left_q != 4'h0) begin
            read_left_q <= read_left_q - 4'h1;
            read_beat   <= read_beat + 3'h1;
        end
    end
    assign read_active = (read_left_q != 4'h0);

    // array read enable only in normal mode
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_array_read_en <= 1'b0;
        end else begin
            o_array_read_en <= any_read & ~calibration_enable;
        end
    end

    // read data mux: array or calibration pattern
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_valid <= 1'b0;
            o_rd_data  <= 8'h00;
        end else begin
            o_rd_valid <= read_active;
            if (!read_active) begin
                o_rd_data <= 8'h00;
            end else if (cal_rd_q) begin
                if (calibration_select == dram_mode_pkg::CAL_SEL_PATTERN) begin
                    o_rd_data <= {8{dram_mode_pkg::CAL_PATTERN[read_beat]}};
                end else begin
                    o_rd_data <= 8'h00; // reserved selections read zero
                end
            end else begin
                o_rd_data <= i_array_rd_data;
            end
        end
    end

    // unused beat index of write burst kept for debug visibility
    logic [2:0] unused_beat;
    assign unused_beat = burst_beat;
endmodule : dram_mode_reg_two_three

// ==== test/dram_ctrl_model.sv ====
// controller model that drives the command and mode word bus of the device
// assumes commands launch on the falling edge of i_mclk and are taken on the rising edge
`timescale 1ns/10ps
module dram_ctrl_model (
    input  wire logic  i_mclk,
    output logic       o_mode_set,
    output logic [2:0] o_bank_addr,
    output logic [18:0] o_addr,
    output logic       o_write_cmd,
    output logic       o_read_cmd,
    output logic       o_read_auto_pre
);
    // ========================================
    // idle bus at time zero
    initial begin
        {o_mode_set, o_write_cmd, o_read_cmd, o_read_auto_pre} = 4'h0;
        o_bank_addr = 3'h0;
        o_addr      = 19'h00000;
    end

    // one mode set, then the command spacing wait with all banks idle
    task automatic mode_write(input logic [2:0] bank, input logic [18:0] word);
        @(negedge i_mclk);
        o_mode_set  = 1'b1;
        o_bank_addr = bank;
        o_addr      = word;
        @(negedge i_mclk);
        o_mode_set  = 1'b0;
        o_bank_addr = ~bank; // released bus no longer shows the last value
        o_addr      = ~word;
        repeat (4) @(negedge i_mclk);
    endtask : mode_write

    // one command pulse: 0 write, 1 read, 2 read with auto precharge
    task automatic issue(input int kind);
        @(negedge i_mclk);
        o_write_cmd     = (kind == 0);
        o_read_cmd      = (kind == 1);
        o_read_auto_pre = (kind == 2);
        @(negedge i_mclk);
        {o_write_cmd, o_read_cmd, o_read_auto_pre} = 3'h0;
    endtask : issue
endmodule : dram_ctrl_model

// ==== test/dram_mode_reg_two_three_chk.sv ====
// checker of mode register two and three behaviour at the block ports
// assumes one clock domain; mode words are mirrored from the command inputs
`timescale 1ns/10ps
module dram_mode_reg_two_three_chk (
    input wire logic        i_mclk,
    input wire logic        i_rst_n,
    input wire logic        i_mode_set,
    input wire logic [2:0]  i_bank_addr,
    input wire logic [18:0] i_addr,
    input wire logic        i_read_cmd,
    input wire logic        i_read_auto_pre,
    input wire logic [3:0]  i_additive_latency,
    input wire logic        i_write_leveling,
    input wire logic [4:0]  o_total_write_latency,
    input wire logic        o_write_data_latch,
    input wire logic        o_refresh_double_rate,
    input wire logic [1:0]  o_termination_sel,
    input wire logic        o_term_high_z,
    input wire logic        o_calibration_mode,
    input wire logic        o_array_read_en,
    input wire logic        o_rd_valid,
    input wire logic [7:0]  o_rd_data
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    // ========================================
    // mirror of both mode words
    logic [18:0] mode_two_q;
    logic [18:0] mode_three_q;
    logic        cal_pat;
    assign cal_pat = o_calibration_mode && (mode_three_q[1:0] == 2'h0);
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_two_q   <= 19'h00000;
            mode_three_q <= 19'h00000;
        end else if (i_mode_set && i_bank_addr == 3'h2) begin
            mode_two_q <= i_addr;
        end else if (i_mode_set && i_bank_addr == 3'h3) begin
            mode_three_q <= i_addr;
        end
    end

    // ========================================
    // properties
    sequence s_set_three;
        i_mode_set && i_bank_addr == 3'h3 ##1 !i_mode_set;
    endsequence
    sequence s_term_burst;
        (o_termination_sel == 2'h2) [*8] ##1 (o_termination_sel != 2'h2);
    endsequence
    // latency register is one cycle behind the field and the additive latency input
    property p_lat;
        (!i_mode_set && $stable(i_additive_latency)) [*2] |=>
            o_total_write_latency == 5'h5 + {2'h0, $past(mode_two_q[5:3])}
                                     + {1'h0, $past(i_additive_latency)};
    endproperty
    property p_cal_mode;
        s_set_three |=> o_calibration_mode == mode_three_q[2];
    endproperty
    property p_rd_valid;
        i_read_cmd || i_read_auto_pre |-> ##2 o_rd_valid [*8];
    endproperty
    property p_pat_first;
        $rose(o_rd_valid) && cal_pat |-> o_rd_data == 8'h00;
    endproperty
    property p_pat_alt;
        o_rd_valid && $past(o_rd_valid) && cal_pat |-> o_rd_data == ~$past(o_rd_data);
    endproperty
    property p_arr_en;
        i_read_cmd || i_read_auto_pre |=> o_array_read_en == !$past(mode_three_q[2]);
    endproperty
    property p_refresh;
        (!i_mode_set) [*2] ##0 !mode_two_q[6] |=> o_refresh_double_rate == mode_two_q[7];
    endproperty
    property p_term;
        o_write_data_latch && mode_two_q[10:9] != 2'h0 && !i_write_leveling |=> s_term_burst;
    endproperty
    property p_no_term_lev;
        i_write_leveling && $past(i_write_leveling, 3) |-> o_termination_sel != 2'h2;
    endproperty
    property p_hiz;
        o_term_high_z == (o_termination_sel == 2'h0);
    endproperty

    a_lat: assert property (p_lat) else $error("write latency mismatch");
    a_cal_mode: assert property (p_cal_mode) else $error("calibration mode mismatch");
    a_rd_valid: assert property (p_rd_valid) else $error("read burst too short");
    a_pat_first: assert property (p_pat_first) else $error("pattern first beat");
    a_pat_alt: assert property (p_pat_alt) else $error("pattern not alternating");
    a_arr_en: assert property (p_arr_en) else $error("array read enable wrong");
    a_refresh: assert property (p_refresh) else $error("refresh rate wrong");
    a_term: assert property (p_term) else $error("write termination span");
    a_no_term_lev: assert property (p_no_term_lev) else $error("term in leveling");
    a_hiz: assert property (p_hiz) else $error("high z flag wrong");
endmodule : dram_mode_reg_two_three_chk

bind dram_mode_reg_two_three dram_mode_reg_two_three_chk i_dram_mode_reg_two_three_chk (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mode_set(i_mode_set), .i_bank_addr(i_bank_addr),
    .i_addr(i_addr), .i_read_cmd(i_read_cmd), .i_read_auto_pre(i_read_auto_pre),
    .i_additive_latency(i_additive_latency), .i_write_leveling(i_write_leveling),
    .o_total_write_latency(o_total_write_latency), .o_write_data_latch(o_write_data_latch),
    .o_refresh_double_rate(o_refresh_double_rate), .o_termination_sel(o_termination_sel),
    .o_term_high_z(o_term_high_z), .o_calibration_mode(o_calibration_mode),
    .o_array_read_en(o_array_read_en), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data)
);

// ==== test/dram_mode_reg_two_three_tb_top.sv ====
// self-checking bench for the mode register two and three block
// assumes the controller model in dram_ctrl_model and the bound checker
`timescale 1ns/10ps
module dram_mode_reg_two_three_tb_top;
    logic i_mclk = 1'b0, i_rst_n = 1'b0;
    logic mode_set, write_cmd, read_cmd, read_auto_pre, latch, dbl, tick, hiz, cal, aren, rv, seen;
    logic [2:0] bank_addr;
    logic [18:0] addr;
    logic [3:0] add_lat = 4'h0;
    logic nom_en = 1'b0, lev = 1'b0, self_ref = 1'b0, term_seen;
    logic [7:0] temp = 8'h19, arr = 8'h5A, rdat;
    logic [4:0] tot;
    logic [1:0] sel;
    logic [10:0] rtab [6] = '{11'h064, 11'h519, 11'h219, 11'h35A, 11'h253, 11'h354};
    int num_errors = 0, n_checks = 0, k;

    always #25 i_mclk = ~i_mclk;

    dram_ctrl_model i_dram_ctrl_model (.i_mclk(i_mclk), .o_mode_set(mode_set),
        .o_bank_addr(bank_addr), .o_addr(addr), .o_write_cmd(write_cmd),
        .o_read_cmd(read_cmd), .o_read_auto_pre(read_auto_pre));
    dram_mode_reg_two_three i_dram_mode_reg_two_three (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_mode_set(mode_set), .i_bank_addr(bank_addr), .i_addr(addr), .i_write_cmd(write_cmd),
        .i_read_cmd(read_cmd), .i_read_auto_pre(read_auto_pre), .i_additive_latency(add_lat),
        .i_nominal_term_en(nom_en), .i_write_leveling(lev), .i_self_refresh(self_ref),
        .i_case_temp(temp), .i_array_rd_data(arr), .o_total_write_latency(tot),
        .o_write_data_latch(latch), .o_refresh_double_rate(dbl), .o_refresh_tick(tick),
        .o_termination_sel(sel), .o_term_high_z(hiz), .o_calibration_mode(cal),
        .o_array_read_en(aren), .o_rd_valid(rv), .o_rd_data(rdat));

    // ========================================
    // checking and closing
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // watch n cycles for a latch or write termination
    task automatic quiet(input int n);
        seen      = 1'b0;
        term_seen = 1'b0;
        repeat (n) begin
            @(negedge i_mclk);
            seen      = seen | (latch === 1'b1);
            term_seen = term_seen | (sel === 2'h2);
        end
    endtask : quiet

    // one read burst, beats checked against array or pattern
    task automatic rd_burst(input int kind, input logic calm);
        i_dram_ctrl_model.issue(kind);
        chk({7'h0, aren}, {7'h0, !calm}, "array read enable");
        for (int b = 0; b < 8; b++) begin
            @(negedge i_mclk);
            chk({7'h0, rv}, 8'h01, "read valid");
            chk(rdat, calm ? (b[0] ? 8'hFF : 8'h00) : arr, "read beat");
        end
    endtask : rd_burst

    // ========================================
    // watchdog
    initial begin
        repeat (5000) @(posedge i_mclk);
        num_errors++;
        end_sim();
    end

    // ========================================
    // main sequence
    initial begin
        repeat (16) @(negedge i_mclk);
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_mclk);
        chk({7'h0, hiz}, 8'h01, "idle high z");
        chk({3'h0, tot}, 8'h05, "reset latency");
        add_lat = 4'h3;
        for (int w = 0; w < 8; w++) begin
            nom_en = w[0];
            i_dram_ctrl_model.mode_write(3'h2, {8'h0, 2'h1, 3'h0, w[2:0], 3'h0});
            chk({3'h0, tot}, 8'(8 + w), "total latency");
            i_dram_ctrl_model.issue(0);
            k = 0;
            while (latch !== 1'b1 && k < 40) begin
                @(negedge i_mclk);
                k++;
            end
            chk(8'(k), 8'(9 + w), "latch delay");
            @(negedge i_mclk);
            chk({6'h0, sel}, 8'h02, "write termination");
            repeat (8) @(negedge i_mclk);
            chk({6'h0, sel}, {7'h0, w[0]}, "nominal restored");
        end
        lev = 1'b1;
        repeat (4) @(negedge i_mclk);
        i_dram_ctrl_model.issue(0);
        quiet(20);
        chk({7'h0, seen}, 8'h01, "leveling write");
        chk({7'h0, term_seen}, 8'h00, "leveling termination");
        lev = 1'b0;
        self_ref = 1'b1;
        for (int r = 0; r < 6; r++) begin
            temp = rtab[r][7:0];
            i_dram_ctrl_model.mode_write(3'h2, {11'h0, rtab[r][10:9], 6'h0});
            chk({7'h0, dbl}, {7'h0, rtab[r][8]}, "double rate");
            k = 0;
            repeat (16) begin
                @(negedge i_mclk);
                k += int'(tick === 1'b1);
            end
            chk(8'(k), rtab[r][8] ? 8'h08 : 8'h04, "tick count");
        end
        self_ref = 1'b0;
        i_dram_ctrl_model.mode_write(3'h0, 19'h00004);
        chk({7'h0, cal}, 8'h00, "bank zero ignored");
        i_dram_ctrl_model.mode_write(3'h3, 19'h00004);
        chk({7'h0, cal}, 8'h01, "calibration on");
        rd_burst(1, 1'b1);
        rd_burst(2, 1'b1);
        i_dram_ctrl_model.issue(0);
        quiet(20);
        chk({7'h0, seen}, 8'h00, "write refused");
        chk({7'h0, term_seen}, 8'h00, "refused termination");
        i_dram_ctrl_model.mode_write(3'h3, 19'h00003);
        chk({7'h0, cal}, 8'h00, "calibration off");
        rd_burst(1, 1'b0);
        chk({3'h0, tot}, 8'h08, "register two kept");
        i_dram_ctrl_model.mode_write(3'h3, 19'h00004);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_mclk);
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_mclk);
        chk({7'h0, cal}, 8'h00, "reset in calibration");
        end_sim();
    end
endmodule : dram_mode_reg_two_three_tb_top
